// ===== hdl/qb_ports_map.svh
// constants for the quasi-bidirectional port block
// assumes a single 100 MHz core clock
`ifndef QB_PORTS_MAP_SVH
`define QB_PORTS_MAP_SVH
`define PORT_WIDTH 8
`define PORT_RESET_LATCH 8'hff
`define CLK_PERIOD_NS 10
// strong transition driver on-time in ns, least time
`define KICK_TIME_NS 20
`define KICK_CYCLES ((`KICK_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_RXD 0
`define BIT_TXD 1
`define BIT_IRQ0 2
`define BIT_IRQ1 3
`define BIT_TMR0 4
`define BIT_TMR1 5
`define BIT_STORE 6
`define BIT_FETCH 7
`endif

// ===== hdl/qb_ports_pkg.sv
// types for the quasi-bidirectional port block
// assumes qb_ports_map.svh for the numbers
`include "qb_ports_map.svh"
package qb_ports_pkg;
	// per-port pad controls
	typedef struct packed {
		logic [7:0] pullDn;
		logic [7:0] strongUp;
		logic [7:0] weakUp;
	} pad_drive_type;
	// alternate functions from the core
	typedef struct packed {
		logic addrEn;
		logic [7:0] addrHigh;
		logic serialEn;
		logic txd;
		logic strobeEn;
		logic storeN;
		logic fetchN;
	} alt_ctl_type;
	// decoded inputs to the core
	typedef struct packed {
		logic rxd;
		logic irq0;
		logic irq1;
		logic tmr0;
		logic tmr1;
	} alt_in_type;
endpackage : qb_ports_pkg

// ===== hdl/quasi_bidir_ports.sv
// quasi-bidirectional ports: upper address port and special function port
// assumes pad cells resolve pull/drive controls; pins asynchronous to clk_sys
//
// What this block does
// - upper port resets high on weak pullup
// - special port latches reset to all ones
// - latch one makes pin a readable input
// - written zero holds strong pulldown until one
// - zero-to-one write pulses strong high driver
// - upper port drives address high byte externally
// - bits 0/1 are serial receive and transmit
// - bits 2-5 feed interrupts and timer inputs
// - bits 6/7 are store and fetch strobes
// - code select low forces external program fetch
`include "qb_ports_map.svh"
module quasi_bidir_ports
	import qb_ports_pkg::*;
#(
	parameter int KICK = `KICK_CYCLES
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic upperWrEn,
	input wire logic [7:0] upperWrData,
	input wire logic specialWrEn,
	input wire logic [7:0] specialWrData,
	input wire alt_ctl_type altCtl,
	input wire logic [7:0] upperPinIn,
	input wire logic [7:0] specialPinIn,
	input wire logic codeSelectPinN,
	output pad_drive_type upperPad,
	output pad_drive_type specialPad,
	output logic [7:0] upperPinRead,
	output logic [7:0] specialPinRead,
	output alt_in_type altIn,
	output logic extCodeFetch
);
	// ****************************************
	// latches
	// ****************************************
	logic [7:0] upperLatch_ff;
	logic [7:0] specialLatch_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			upperLatch_ff <= `PORT_RESET_LATCH;
			specialLatch_ff <= `PORT_RESET_LATCH;
		end else begin
			if (upperWrEn) begin
				upperLatch_ff <= upperWrData;
			end
			if (specialWrEn) begin
				specialLatch_ff <= specialWrData;
			end
		end
	end
	// ****************************************
	// effective pin values (alternate overrides latch)
	// ****************************************
	logic [7:0] upperEff;
	logic [7:0] specialEff;
	always_comb begin
		upperEff = altCtl.addrEn ? altCtl.addrHigh : upperLatch_ff;
		specialEff = specialLatch_ff;
		if (altCtl.serialEn) begin
			specialEff[`BIT_TXD] = altCtl.txd;
			specialEff[`BIT_RXD] = 1'b1; // receive pin must float as input
		end
		if (altCtl.strobeEn) begin
			specialEff[`BIT_STORE] = altCtl.storeN;
			specialEff[`BIT_FETCH] = altCtl.fetchN;
		end
	end
	// ****************************************
	// per-bit drivers
	// ****************************************
	logic [7:0] upperPrev_ff;
	logic [7:0] specialPrev_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			upperPrev_ff <= 8'hff;
			specialPrev_ff <= 8'hff;
		end else begin
			upperPrev_ff <= upperEff;
			specialPrev_ff <= specialEff;
		end
	end
	logic [7:0] upKickU;
	logic [7:0] upKickS;
	genvar g;
	generate
		for (g = 0; g < `PORT_WIDTH; g++) begin : gBit
			logic [3:0] kickU_ff;
			logic [3:0] kickS_ff;
			// counts reload on each rising edge of the pin value
			always_ff @(posedge clk_sys) begin
				if (sys_rst) begin
					kickU_ff <= 4'h0;
					kickS_ff <= 4'h0;
				end else begin
					if (upperEff[g] && !upperPrev_ff[g]) begin
						kickU_ff <= 4'(KICK);
					end else if (kickU_ff != 4'h0) begin
						kickU_ff <= kickU_ff - 4'h1;
					end
					if (specialEff[g] && !specialPrev_ff[g]) begin
						kickS_ff <= 4'(KICK);
					end else if (kickS_ff != 4'h0) begin
						kickS_ff <= kickS_ff - 4'h1;
					end
				end
			end
			assign upKickU[g] = (kickU_ff != 4'h0);
			assign upKickS[g] = (kickS_ff != 4'h0);
		end
	endgenerate
	// pad controls registered so outputs come from flip-flops
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			upperPad <= '{pullDn: 8'h00, strongUp: 8'h00, weakUp: 8'hff};
			specialPad <= '{pullDn: 8'h00, strongUp: 8'h00, weakUp: 8'hff};
		end else begin
			upperPad.pullDn <= ~upperEff;
			upperPad.weakUp <= upperEff;
			upperPad.strongUp <= upperEff & ((upperEff & ~upperPrev_ff) | upKickU);
			specialPad.pullDn <= ~specialEff;
			specialPad.weakUp <= specialEff;
			specialPad.strongUp <= specialEff & ((specialEff & ~specialPrev_ff) | upKickS);
		end
	end
	// ****************************************
	// input synchronisers (three stages, 2nd/3rd agree)
	// ****************************************
	logic [8:0] syncA_ff;
	logic [8:0] syncB_ff;
	logic [8:0] syncC_ff;
	logic [8:0] stable_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			syncA_ff <= 9'h1ff;
			syncB_ff <= 9'h1ff;
			syncC_ff <= 9'h1ff;
			stable_ff <= 9'h1ff;
		end else begin
			syncA_ff <= {codeSelectPinN, specialPinIn};
			syncB_ff <= syncA_ff;
			syncC_ff <= syncB_ff;
			for (int i = 0; i < 9; i++) begin
				if (syncB_ff[i] == syncC_ff[i]) begin
					stable_ff[i] <= syncC_ff[i];
				end
			end
		end
	end
	logic [7:0] upA_ff;
	logic [7:0] upB_ff;
	logic [7:0] upC_ff;
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			upA_ff <= 8'hff;
			upB_ff <= 8'hff;
			upC_ff <= 8'hff;
			upperPinRead <= 8'hff;
		end else begin
			upA_ff <= upperPinIn;
			upB_ff <= upA_ff;
			upC_ff <= upB_ff;
			for (int i = 0; i < 8; i++) begin
				if (upB_ff[i] == upC_ff[i]) begin
					upperPinRead[i] <= upC_ff[i];
				end
			end
		end
	end
	assign specialPinRead = stable_ff[7:0];
	// ****************************************
	// alternate inputs and code select
	// ****************************************
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			altIn <= '{rxd: 1'b1, irq0: 1'b1, irq1: 1'b1, tmr0: 1'b1, tmr1: 1'b1};
			extCodeFetch <= 1'b0;
		end else begin
			altIn.rxd <= stable_ff[`BIT_RXD];
			altIn.irq0 <= stable_ff[`BIT_IRQ0];
			altIn.irq1 <= stable_ff[`BIT_IRQ1];
			altIn.tmr0 <= stable_ff[`BIT_TMR0];
			altIn.tmr1 <= stable_ff[`BIT_TMR1];
			extCodeFetch <= ~stable_ff[8];
		end
	end
	// ****************************************
	// assertion sequences
	// ****************************************
	// rise of one upper bit, then its kick counter freshly loaded
	sequence s_upper_rise2;
		upperEff[2] && !upperPrev_ff[2];
	endsequence
	sequence s_kick_loaded2;
		(gBit[2].kickU_ff == 4'(KICK)) && upperPad.strongUp[2];
	endsequence

	// ****************************************
	// assertions
	// ****************************************
	a_zero_pulls_down: assert property (@(posedge clk_sys) disable iff (sys_rst)
		upperWrEn && upperWrData[0] == 1'b0 && !altCtl.addrEn |=> ##1 upperPad.pullDn[0])
		else $error("written zero did not pull down");
	a_kick_on_rise: assert property (@(posedge clk_sys) disable iff (sys_rst)
		upperEff[0] && !upperPrev_ff[0] |=> upperPad.strongUp[0])
		else $error("no strong kick on rise");
	a_kick_ends: assert property (@(posedge clk_sys) disable iff (sys_rst)
		$rose(upperPad.strongUp[1]) |-> ##[1:4] !upperPad.strongUp[1])
		else $error("strong drive did not end");
	a_addr_override: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.addrEn |=> upperPad.pullDn == ~$past(altCtl.addrHigh))
		else $error("address byte not driven");
	a_txd_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.serialEn |=> specialPad.pullDn[1] == !$past(altCtl.txd))
		else $error("transmit pin wrong");
	a_irq_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altIn.irq0 == $past(stable_ff[2]))
		else $error("interrupt input wrong");
	a_strobe_drive: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.strobeEn |=> specialPad.pullDn[7:6] == ~$past({altCtl.fetchN, altCtl.storeN}))
		else $error("strobe pin wrong");
	a_code_select: assert property (@(posedge clk_sys) disable iff (sys_rst)
		extCodeFetch == !$past(stable_ff[8]))
		else $error("code select wrong");
	a_one_weak: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(specialPad.weakUp & specialPad.pullDn) == 8'h00)
		else $error("pullup and pulldown both on");

	// ****************************************
	// reset states
	// ****************************************
	a_reset_weak_high: assert property (@(posedge clk_sys) $past(sys_rst) |->
		upperPad.weakUp == 8'hff && upperPad.pullDn == 8'h00 && upperPad.strongUp == 8'h00)
		else $error("upper port not weak high after reset");
	a_reset_latch_ones: assert property (@(posedge clk_sys) $past(sys_rst) |->
		specialLatch_ff == `PORT_RESET_LATCH && specialPad.pullDn == 8'h00)
		else $error("special latch not all ones after reset");

	// ****************************************
	// latch, pulldown and kick
	// ****************************************
	a_latch_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!upperWrEn |=> upperLatch_ff == $past(upperLatch_ff))
		else $error("upper latch changed without write");
	a_special_holds: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!specialWrEn |=> specialLatch_ff == $past(specialLatch_ff))
		else $error("special latch changed without write");
	a_one_stops_pull: assert property (@(posedge clk_sys) disable iff (sys_rst)
		upperWrEn && upperWrData[3] && !altCtl.addrEn ##1 !altCtl.addrEn |=> !upperPad.pullDn[3])
		else $error("written one left pulldown on");
	a_kick_length: assert property (@(posedge clk_sys) disable iff (sys_rst)
		s_upper_rise2 |=> s_kick_loaded2)
		else $error("kick counter not loaded on rise");
	a_special_kick: assert property (@(posedge clk_sys) disable iff (sys_rst)
		specialEff[1] && !specialPrev_ff[1] |=> specialPad.strongUp[1])
		else $error("no strong kick on special rise");
	a_strong_only_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(upperPad.strongUp & ~upperPad.weakUp) == 8'h00)
		else $error("strong drive on a low pin");

	// ****************************************
	// alternate roles
	// ****************************************
	a_addr_weak: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.addrEn |=> upperPad.weakUp == $past(altCtl.addrHigh))
		else $error("address byte not on pullups");
	a_addr_beats_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.addrEn && upperWrEn |=> upperPad.weakUp == $past(altCtl.addrHigh))
		else $error("latch write overrode address");
	a_latch_when_idle: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!altCtl.addrEn |=> upperPad.weakUp == $past(upperLatch_ff))
		else $error("idle port not showing latch");
	a_rxd_released: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.serialEn |=> !specialPad.pullDn[0])
		else $error("receive pin not released");
	a_rxd_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altIn.rxd == $past(stable_ff[`BIT_RXD]))
		else $error("receive input wrong");
	a_irq1_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altIn.irq1 == $past(stable_ff[`BIT_IRQ1]))
		else $error("second interrupt input wrong");
	a_tmr0_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altIn.tmr0 == $past(stable_ff[`BIT_TMR0]))
		else $error("first timer input wrong");
	a_tmr1_path: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altIn.tmr1 == $past(stable_ff[`BIT_TMR1]))
		else $error("second timer input wrong");
	a_store_low: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.strobeEn && !altCtl.storeN |=> specialPad.pullDn[6])
		else $error("store strobe not driven low");
	a_fetch_high: assert property (@(posedge clk_sys) disable iff (sys_rst)
		altCtl.strobeEn && altCtl.fetchN |=> !specialPad.pullDn[7])
		else $error("fetch strobe not released");

	// ****************************************
	// input sampling
	// ****************************************
	a_read_agree: assert property (@(posedge clk_sys) disable iff (sys_rst)
		syncB_ff[0] == syncC_ff[0] |=> stable_ff[0] == $past(syncC_ff[0]))
		else $error("agreed special input not taken");
	a_upper_agree: assert property (@(posedge clk_sys) disable iff (sys_rst)
		upB_ff[0] == upC_ff[0] |=> upperPinRead[0] == $past(upC_ff[0]))
		else $error("agreed upper input not taken");
	a_code_internal: assert property (@(posedge clk_sys) disable iff (sys_rst)
		stable_ff[8] |=> !extCodeFetch)
		else $error("external fetch while select high");
endmodule : quasi_bidir_ports

// ===== bench/qb_board_model.sv
// board model: resolves both ports' pins from pad enables and outside drivers
// assumes pad enables are active high and an undriven pin rests on its pullup
module qb_board_model
	import qb_ports_pkg::*;
(
	input pad_drive_type upperPad,
	input pad_drive_type specialPad,
	input logic [7:0] upperExtEn,
	input logic [7:0] upperExtVal,
	input logic [7:0] specialExtEn,
	input logic [7:0] specialExtVal,
	output logic [7:0] upperPinIn,
	output logic [7:0] specialPinIn
);
	timeunit 1ns;
	timeprecision 100ps;
	// ***************
	// pin resolution
	// ***************
	// pulldown wins; an outside driver only beats the weak pullup
	function automatic logic [7:0] wire_level(pad_drive_type p, logic [7:0] en, logic [7:0] v);
		return ~p.pullDn & (p.strongUp | ~en | v);
	endfunction : wire_level

	assign upperPinIn = wire_level(upperPad, upperExtEn, upperExtVal);
	assign specialPinIn = wire_level(specialPad, specialExtEn, specialExtVal);
endmodule : qb_board_model

// ===== bench/quasi_bidir_ports_tb.sv
// self-checking bench for the quasi-bidirectional port block
// assumes qb_board_model closes the pins; inputs move 1 ns after each edge
module quasi_bidir_ports_tb
	import qb_ports_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int KICK = 2;
	logic clk_sys = 1'b0, sys_rst = 1'b1, upperWrEn = 1'b0, specialWrEn = 1'b0;
	logic codeSelectPinN = 1'b1, extCodeFetch;
	logic [7:0] upperWrData = 8'h00, specialWrData = 8'h00, upperPinIn, specialPinIn;
	logic [7:0] upperExtEn = 8'h00, upperExtVal = 8'h00, specialExtEn = 8'h00;
	logic [7:0] specialExtVal = 8'h00, upperPinRead, specialPinRead;
	alt_ctl_type altCtl = '0;
	pad_drive_type upperPad, specialPad;
	alt_in_type altIn;
	int errorCnt = 0, nChecks = 0;

	always #5 clk_sys = ~clk_sys;

	quasi_bidir_ports #(.KICK(KICK)) u_quasi_bidir_ports (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.upperWrEn(upperWrEn), .upperWrData(upperWrData), .specialWrEn(specialWrEn),
		.specialWrData(specialWrData), .altCtl(altCtl), .upperPinIn(upperPinIn),
		.specialPinIn(specialPinIn), .codeSelectPinN(codeSelectPinN), .upperPad(upperPad),
		.specialPad(specialPad), .upperPinRead(upperPinRead), .specialPinRead(specialPinRead),
		.altIn(altIn), .extCodeFetch(extCodeFetch));

	qb_board_model u_qb_board_model (.upperPad(upperPad), .specialPad(specialPad),
		.upperExtEn(upperExtEn), .upperExtVal(upperExtVal), .specialExtEn(specialExtEn),
		.specialExtVal(specialExtVal), .upperPinIn(upperPinIn), .specialPinIn(specialPinIn));

	// ***************
	// tasks
	// ***************
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		nChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// pads answer one edge after the write edge
	task automatic wr(input logic up, input logic [7:0] d);
		upperWrEn = up;
		specialWrEn = ~up;
		upperWrData = d;
		specialWrData = d;
		tick(1);
		upperWrEn = 1'b0;
		specialWrEn = 1'b0;
		tick(2);
	endtask : wr

	task automatic closeOut();
		$display("checks %0d mismatches %0d", nChecks, errorCnt);
		if (errorCnt == 0 && nChecks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : closeOut

	task automatic testZeroOne();
		wr(1'b1, 8'h5a);
		chk(upperPad.pullDn, 8'ha5);
		wr(1'b1, 8'hff);
		chk(upperPad.strongUp, 8'ha5);
		chk(upperPad.pullDn, 8'h00);
		tick(KICK + 1);
		chk(upperPad, {8'h00, 8'h00, 8'hff});
		wr(1'b0, 8'h0f);
		chk(specialPad.pullDn, 8'hf0);
		wr(1'b0, 8'hff);
		chk(specialPad.strongUp, 8'hf0);
		$display("zero/one write test done");
	endtask : testZeroOne

	task automatic testInputs();
		specialExtEn = 8'h3d;
		specialExtVal = 8'h08;
		upperExtEn = 8'hff;
		upperExtVal = 8'h96;
		tick(8);
		chk(specialPinRead, 8'hca);
		chk(upperPinRead, 8'h96);
		chk(altIn, 5'b00100);
		specialExtEn = 8'h00;
		upperExtEn = 8'h00;
		tick(8);
		chk(altIn, 5'h1f);
		$display("input test done");
	endtask : testInputs

	task automatic testAlt();
		wr(1'b1, 8'h00);
		altCtl = '{addrEn: 1'b1, addrHigh: 8'h3c, serialEn: 1'b1, txd: 1'b0,
			strobeEn: 1'b1, storeN: 1'b0, fetchN: 1'b1};
		tick(2);
		chk(upperPad.pullDn, 8'hc3);
		chk(specialPad.pullDn, 8'h42);
		altCtl = '0;
		tick(2);
		chk(upperPad.pullDn, 8'hff);
		codeSelectPinN = 1'b0;
		tick(8);
		chk(extCodeFetch, 1'b1);
		codeSelectPinN = 1'b1;
		tick(8);
		chk(extCodeFetch, 1'b0);
		$display("alternate test done");
	endtask : testAlt

	initial begin
		#20000;
		errorCnt++;
		closeOut();
	end

	initial begin
		tick(5);
		sys_rst = 1'b0;
		tick(1);
		chk(upperPad, {8'h00, 8'h00, 8'hff});
		chk(specialPad, {8'h00, 8'h00, 8'hff});
		testZeroOne();
		testInputs();
		testAlt();
		closeOut();
	end
endmodule : quasi_bidir_ports_tb
